/* File: hdl/vdram_ctrl.sv */
// Single-bank video DRAM controller: decode, dual-token sequencer, refresh and byte enables.
`timescale 1ns/10ps
module vdram_ctrl #(
  parameter int REFRESH_COUNT = vdram_ctrl_pkg::REFRESH_INTERVAL
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Processor request side
  input wire logic [7:0] addrUpper,
  input wire logic instrRequest,
  input wire logic instrRequestQual,
  input wire logic dataRequest,
  input wire logic dataRequestQual,
  input wire logic dataWrite,
  input wire logic instr_burst_request_in,
  input wire logic bus_invalid,
  input wire logic size_option_hi,
  input wire logic size_option_lo,
  input wire logic addr_bit_one,
  input wire logic addr_bit_zero,
  // Processor response side
  output logic instr_burst_acknowledge,
  output logic instr_ready,
  output logic data_ready,
  output logic data_pipeline_enable,
  // Memory control side
  output logic rowStrobe,
  output logic columnStrobe,
  output logic addrMuxColumn,
  output logic transferEnable,
  output logic instrOutputEnable,
  output logic shiftClockEnable,
  output logic bankSelect,
  output logic [3:0] byte_write_enables,
  // Status
  output logic refreshPending
);

  logic rstMeta_reg;
  logic rstSync_reg;
  logic burstReq_reg;
  logic refreshReq_reg;
  logic [vdram_ctrl_pkg::REFRESH_WIDTH-1:0] refreshCount_reg;
  logic writeCycle_reg;
  vdram_ctrl_pkg::random_state_t random_port_token;
  vdram_ctrl_pkg::random_state_t randomNext;
  vdram_ctrl_pkg::serial_state_t serial_port_token;
  vdram_ctrl_pkg::serial_state_t serialNext;
  vdram_ctrl_pkg::hold_t hold_reg;
  logic instr_start_decode;
  logic dataStartDecode;
  logic refreshAck;
  logic refreshCasSetup;

  localparam logic [vdram_ctrl_pkg::REFRESH_WIDTH-1:0] REFRESH_LAST =
    vdram_ctrl_pkg::REFRESH_WIDTH'(REFRESH_COUNT - 1);

  // Big-endian lane decode: lane 3 is bits 31..24 at byte address 0.
  function automatic logic [3:0] laneEnables(input logic [1:0] size, input logic [1:0] addr);
    logic [3:0] lanes;
    lanes = 4'h0;
    unique case (size)
      vdram_ctrl_pkg::SIZE_BYTE: lanes = 4'h8 >> addr;
      vdram_ctrl_pkg::SIZE_HALF: lanes = addr[1] ? 4'h3 : 4'hc;
      default: lanes = 4'hf;
    endcase
    return lanes;
  endfunction

  // Reset release synchroniser; assertion stays asynchronous.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // The raw burst request settles too late in the cycle to steer state logic.
  always_ff @(posedge clock or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      burstReq_reg <= 1'b0;
    end else begin
      burstReq_reg <= instr_burst_request_in;
    end
  end

  // Refresh interval counter runs regardless of traffic.
  always_ff @(posedge clock or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      refreshCount_reg <= '0;
    end else if (refreshCount_reg == REFRESH_LAST) begin
      refreshCount_reg <= '0;
    end else begin
      refreshCount_reg <= refreshCount_reg + 1'b1;
    end
  end

  assign refreshAck = (random_port_token == vdram_ctrl_pkg::REFRESH_ROW_STATE) &&
                      (hold_reg == vdram_ctrl_pkg::HOLD_NONE);

  // Expiry wins over acknowledge so no interval is lost.
  always_ff @(posedge clock or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      refreshReq_reg <= 1'b0;
    end else if (refreshCount_reg == REFRESH_LAST) begin
      refreshReq_reg <= 1'b1;
    end else if (refreshAck) begin
      refreshReq_reg <= 1'b0;
    end
  end

  assign refreshPending = refreshReq_reg;

  // Start indications are gated with idle and a clear refresh request.
  always_comb begin
    logic selected;
    selected = (addrUpper == vdram_ctrl_pkg::BLOCK_SELECT);
    instr_start_decode = selected && instrRequest && instrRequestQual &&
                         !refreshReq_reg && !bus_invalid &&
                         (random_port_token == vdram_ctrl_pkg::RP_IDLE) &&
                         (serial_port_token == vdram_ctrl_pkg::SP_IDLE);
    dataStartDecode = selected && dataRequest && dataRequestQual &&
                      !refreshReq_reg && !bus_invalid &&
                      (random_port_token == vdram_ctrl_pkg::RP_IDLE);
  end

  // Random-port token; refresh hold states count inside the refresh row state.
  always_comb begin
    randomNext = random_port_token;
    unique case (random_port_token)
      vdram_ctrl_pkg::RP_IDLE: begin
        if (refreshReq_reg) begin
          randomNext = vdram_ctrl_pkg::REFRESH_ROW_STATE;
        end else if (instr_start_decode) begin
          randomNext = vdram_ctrl_pkg::INSTR_ROW_STROBE_STATE;
        end else if (dataStartDecode) begin
          randomNext = vdram_ctrl_pkg::DATA_ROW_STROBE_STATE;
        end
      end
      vdram_ctrl_pkg::INSTR_ROW_STROBE_STATE:
        randomNext = vdram_ctrl_pkg::INSTR_COLUMN_STROBE_STATE;
      vdram_ctrl_pkg::INSTR_COLUMN_STROBE_STATE:
        randomNext = vdram_ctrl_pkg::INSTR_WAIT_STATE;
      vdram_ctrl_pkg::INSTR_WAIT_STATE:
        randomNext = vdram_ctrl_pkg::PRECHARGE_FIRST_STATE;
      vdram_ctrl_pkg::DATA_ROW_STROBE_STATE:
        randomNext = vdram_ctrl_pkg::DATA_COLUMN_STROBE_STATE;
      vdram_ctrl_pkg::DATA_COLUMN_STROBE_STATE:
        randomNext = vdram_ctrl_pkg::DATA_WAIT_STATE;
      vdram_ctrl_pkg::DATA_WAIT_STATE:
        randomNext = vdram_ctrl_pkg::DATA_COMPLETE_STATE;
      vdram_ctrl_pkg::DATA_COMPLETE_STATE:
        randomNext = vdram_ctrl_pkg::PRECHARGE_FIRST_STATE;
      vdram_ctrl_pkg::REFRESH_ROW_STATE: begin
        if (hold_reg == vdram_ctrl_pkg::HOLD_B) begin
          randomNext = vdram_ctrl_pkg::PRECHARGE_FIRST_STATE;
        end
      end
      vdram_ctrl_pkg::PRECHARGE_FIRST_STATE:
        randomNext = vdram_ctrl_pkg::PRECHARGE_SECOND_STATE;
      vdram_ctrl_pkg::PRECHARGE_SECOND_STATE:
        randomNext = vdram_ctrl_pkg::RP_IDLE;
      default:
        randomNext = vdram_ctrl_pkg::RP_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      random_port_token <= vdram_ctrl_pkg::RP_IDLE;
    end else begin
      random_port_token <= randomNext;
    end
  end

  // Refresh hold_a and hold_b states, the two extra RAS cycles.
  always_ff @(posedge clock or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      hold_reg <= vdram_ctrl_pkg::HOLD_NONE;
    end else if (random_port_token != vdram_ctrl_pkg::REFRESH_ROW_STATE) begin
      hold_reg <= vdram_ctrl_pkg::HOLD_NONE;
    end else if (hold_reg == vdram_ctrl_pkg::HOLD_NONE) begin
      hold_reg <= vdram_ctrl_pkg::HOLD_A;
    end else begin
      hold_reg <= vdram_ctrl_pkg::HOLD_B;
    end
  end

  // Latch read or write for the data sequence.
  always_ff @(posedge clock or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      writeCycle_reg <= 1'b0;
    end else if (dataStartDecode && !refreshReq_reg &&
                 random_port_token == vdram_ctrl_pkg::RP_IDLE && !instr_start_decode) begin
      writeCycle_reg <= dataWrite;
    end
  end

  // Serial token: no address counter; the row loads once and shift clocks advance it.
  always_comb begin
    serialNext = serial_port_token;
    unique case (serial_port_token)
      vdram_ctrl_pkg::SP_IDLE: begin
        if (instr_start_decode) begin
          serialNext = vdram_ctrl_pkg::SERIAL_DELAY_ONE;
        end
      end
      vdram_ctrl_pkg::SERIAL_DELAY_ONE:
        serialNext = vdram_ctrl_pkg::SERIAL_DELAY_TWO;
      vdram_ctrl_pkg::SERIAL_DELAY_TWO:
        serialNext = vdram_ctrl_pkg::SERIAL_DELAY_THREE;
      vdram_ctrl_pkg::SERIAL_DELAY_THREE:
        serialNext = vdram_ctrl_pkg::SERIAL_DELAY_FOUR;
      vdram_ctrl_pkg::SERIAL_DELAY_FOUR:
        serialNext = vdram_ctrl_pkg::SERIAL_BURST_STATE;
      vdram_ctrl_pkg::SERIAL_BURST_STATE: begin
        // The processor ends the burst itself; nothing here preempts it.
        if (!burstReq_reg) begin
          serialNext = vdram_ctrl_pkg::SP_IDLE;
        end
      end
      default:
        serialNext = vdram_ctrl_pkg::SP_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      serial_port_token <= vdram_ctrl_pkg::SP_IDLE;
    end else begin
      serial_port_token <= serialNext;
    end
  end

  // Mealy outputs: some depend on this cycle's burst request and size and address inputs.
  assign refreshCasSetup = (random_port_token == vdram_ctrl_pkg::RP_IDLE) && refreshReq_reg;

  always_comb begin
    rowStrobe = random_port_token inside {vdram_ctrl_pkg::INSTR_ROW_STROBE_STATE,
      vdram_ctrl_pkg::INSTR_COLUMN_STROBE_STATE, vdram_ctrl_pkg::INSTR_WAIT_STATE,
      vdram_ctrl_pkg::DATA_ROW_STROBE_STATE, vdram_ctrl_pkg::DATA_COLUMN_STROBE_STATE,
      vdram_ctrl_pkg::DATA_WAIT_STATE, vdram_ctrl_pkg::REFRESH_ROW_STATE};
    columnStrobe = refreshCasSetup ||
      (random_port_token inside {vdram_ctrl_pkg::INSTR_COLUMN_STROBE_STATE,
      vdram_ctrl_pkg::INSTR_WAIT_STATE, vdram_ctrl_pkg::DATA_COLUMN_STROBE_STATE,
      vdram_ctrl_pkg::DATA_WAIT_STATE, vdram_ctrl_pkg::REFRESH_ROW_STATE});
    addrMuxColumn = random_port_token inside {vdram_ctrl_pkg::INSTR_COLUMN_STROBE_STATE,
      vdram_ctrl_pkg::INSTR_WAIT_STATE, vdram_ctrl_pkg::DATA_COLUMN_STROBE_STATE,
      vdram_ctrl_pkg::DATA_WAIT_STATE};
    transferEnable = random_port_token inside {vdram_ctrl_pkg::INSTR_ROW_STROBE_STATE,
      vdram_ctrl_pkg::INSTR_COLUMN_STROBE_STATE};
    instrOutputEnable = (random_port_token == vdram_ctrl_pkg::INSTR_ROW_STROBE_STATE) ||
      (serial_port_token != vdram_ctrl_pkg::SP_IDLE);
    // Acknowledge only after both strobes went active, since the address is not latched.
    instr_burst_acknowledge = (serial_port_token == vdram_ctrl_pkg::SERIAL_DELAY_TWO);
    shiftClockEnable = (serial_port_token inside {vdram_ctrl_pkg::SERIAL_DELAY_THREE,
      vdram_ctrl_pkg::SERIAL_DELAY_FOUR}) ||
      ((serial_port_token == vdram_ctrl_pkg::SERIAL_BURST_STATE) &&
       instr_burst_request_in);
    bankSelect = serial_port_token inside {vdram_ctrl_pkg::SERIAL_DELAY_THREE,
      vdram_ctrl_pkg::SERIAL_DELAY_FOUR, vdram_ctrl_pkg::SERIAL_BURST_STATE};
    instr_ready = (serial_port_token == vdram_ctrl_pkg::SERIAL_BURST_STATE) &&
      (random_port_token != vdram_ctrl_pkg::INSTR_ROW_STROBE_STATE);
    data_pipeline_enable = (random_port_token == vdram_ctrl_pkg::DATA_COLUMN_STROBE_STATE);
    data_ready = writeCycle_reg ?
      (random_port_token == vdram_ctrl_pkg::DATA_COLUMN_STROBE_STATE) :
      (random_port_token == vdram_ctrl_pkg::DATA_COMPLETE_STATE);
    byte_write_enables = 4'h0;
    if (writeCycle_reg && (random_port_token inside {vdram_ctrl_pkg::DATA_COLUMN_STROBE_STATE,
        vdram_ctrl_pkg::DATA_WAIT_STATE})) begin
      byte_write_enables = laneEnables({size_option_hi, size_option_lo},
                                       {addr_bit_one, addr_bit_zero});
    end
  end

endmodule

/* File: hdl/vdram_ctrl_pkg.sv */
// Package with constants and state types for the single-bank video DRAM controller.
package vdram_ctrl_pkg;

  // Refresh interval in cycles between refresh requests.
  localparam int REFRESH_INTERVAL = 256;
  localparam int REFRESH_WIDTH = 12;
  // Block select pattern for the upper address byte.
  localparam logic [7:0] BLOCK_SELECT = 8'h00;
  // Size option encodings for byte writes.
  localparam logic [1:0] SIZE_WORD = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_HALF = 2'h2;
  // Timing figures in ns and the clock period.
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int RAS_MIN_NS = 120;
  localparam int CAS_MIN_NS = 60;
  localparam int PRECHARGE_MIN_NS = 100;
  localparam int RAS_MIN_CYCLES = (RAS_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // Random-port token states, one-hot.
  typedef enum logic [10:0] {
    RP_IDLE                   = 11'h001,
    INSTR_ROW_STROBE_STATE    = 11'h002,
    INSTR_COLUMN_STROBE_STATE = 11'h004,
    INSTR_WAIT_STATE          = 11'h008,
    DATA_ROW_STROBE_STATE     = 11'h010,
    DATA_COLUMN_STROBE_STATE  = 11'h020,
    DATA_WAIT_STATE           = 11'h040,
    DATA_COMPLETE_STATE       = 11'h080,
    PRECHARGE_FIRST_STATE     = 11'h100,
    PRECHARGE_SECOND_STATE    = 11'h200,
    REFRESH_ROW_STATE         = 11'h400
  } random_state_t;

  // Serial-port token states, one-hot.
  typedef enum logic [5:0] {
    SP_IDLE            = 6'h01,
    SERIAL_DELAY_ONE   = 6'h02,
    SERIAL_DELAY_TWO   = 6'h04,
    SERIAL_DELAY_THREE = 6'h08,
    SERIAL_DELAY_FOUR  = 6'h10,
    SERIAL_BURST_STATE = 6'h20
  } serial_state_t;

  // Refresh hold states share a small counter with the row state.
  typedef enum logic [2:0] {
    HOLD_NONE = 3'h1,
    HOLD_A    = 3'h2,
    HOLD_B    = 3'h4
  } hold_t;

endpackage

/* File: verif/vdram_ctrl_properties.sv */
// Port assertions for the video DRAM controller.
`timescale 1ns/10ps
module vdram_ctrl_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Request qualifiers
  input wire logic dataWrite,
  input wire logic bus_invalid,
  // Responses
  input wire logic instr_burst_acknowledge,
  input wire logic instr_ready,
  input wire logic data_ready,
  input wire logic data_pipeline_enable,
  // Memory control
  input wire logic rowStrobe,
  input wire logic columnStrobe,
  input wire logic addrMuxColumn,
  input wire logic transferEnable,
  input wire logic instrOutputEnable,
  input wire logic bankSelect,
  input wire logic [3:0] byte_write_enables,
  input wire logic refreshPending
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Three low cycles of the row strobe make up the precharge gap.
  sequence s_precharge;
    !rowStrobe [*3];
  endsequence
  sequence s_data_row;
    $rose(rowStrobe) && !columnStrobe && !transferEnable;
  endsequence
  sequence s_instr_row;
    $rose(rowStrobe) && !columnStrobe && transferEnable;
  endsequence
  property p_instr_seq;
    s_instr_row |-> instrOutputEnable && !instr_ready ##1 columnStrobe && addrMuxColumn
      && instr_burst_acknowledge ##1 rowStrobe && bankSelect ##1 s_precharge;
  endproperty
  a_instr_seq: assert property (p_instr_seq) else $error("row transfer out of order");
  property p_ready;
    instr_burst_acknowledge |-> ##3 instr_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("burst ready late");
  property p_read;
    s_data_row ##0 !dataWrite |=> data_pipeline_enable && columnStrobe && !data_ready
      ##1 !data_ready ##1 data_ready ##1 !data_ready && !rowStrobe;
  endproperty
  a_read: assert property (p_read) else $error("read sequence wrong");
  property p_write;
    s_data_row ##0 dataWrite |=> data_ready && data_pipeline_enable
      ##1 !data_ready && byte_write_enables != 4'h0 ##1 !data_ready ##1 s_precharge;
  endproperty
  a_write: assert property (p_write) else $error("write sequence wrong");
  property p_refresh;
    $rose(rowStrobe) && columnStrobe |-> $past(columnStrobe) ##0
      (rowStrobe && columnStrobe) [*3] ##1 s_precharge;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh sequence wrong");
  property p_ref_first;
    $rose(rowStrobe) && $past(refreshPending) |-> columnStrobe;
  endproperty
  a_ref_first: assert property (p_ref_first) else $error("refresh lost priority");
  property p_bus_invalid;
    bus_invalid |=> !($rose(rowStrobe) && !columnStrobe);
  endproperty
  a_bus_invalid: assert property (p_bus_invalid) else $error("start while bus invalid");
  property p_hold_addr;
    instr_burst_acknowledge || data_pipeline_enable |-> rowStrobe && columnStrobe;
  endproperty
  a_hold_addr: assert property (p_hold_addr) else $error("address released early");
  property p_bwe;
    byte_write_enables != 4'h0 |-> rowStrobe && columnStrobe && dataWrite;
  endproperty
  a_bwe: assert property (p_bwe) else $error("byte enable outside write");
endmodule
bind vdram_ctrl vdram_ctrl_properties i_props (
  .clock(clock), .nrst(nrst), .dataWrite(dataWrite), .bus_invalid(bus_invalid),
  .instr_burst_acknowledge(instr_burst_acknowledge), .instr_ready(instr_ready),
  .data_ready(data_ready), .data_pipeline_enable(data_pipeline_enable),
  .rowStrobe(rowStrobe), .columnStrobe(columnStrobe), .addrMuxColumn(addrMuxColumn),
  .transferEnable(transferEnable), .instrOutputEnable(instrOutputEnable),
  .bankSelect(bankSelect), .byte_write_enables(byte_write_enables),
  .refreshPending(refreshPending)
);

/* File: verif/cpu_model.sv */
// Processor model: raises requests, holds them until answered and ends bursts.
`timescale 1ns/10ps
module cpu_model (
  // Clock and commands
  input wire logic clock,
  input wire logic goInstr,
  input wire logic goData,
  input wire logic [7:0] burstLen,
  input wire logic noQual,
  // Answers from memory
  input wire logic instr_burst_acknowledge,
  input wire logic instr_ready,
  input wire logic data_ready,
  // Requests to memory
  output logic instrRequest,
  output logic instrRequestQual,
  output logic dataRequest,
  output logic dataRequestQual,
  output logic instr_burst_request_in
);
  logic [7:0] words;
  initial begin
    {instrRequest, instrRequestQual, dataRequest, dataRequestQual} = 4'h0;
    instr_burst_request_in = 1'b0;
    words = 8'h00;
  end
  // The memory does not latch the address, so requests stay up until answered.
  always @(posedge clock) begin
    if (goInstr) begin
      {instrRequest, instrRequestQual, instr_burst_request_in} <= 3'h7;
      words <= 8'h00;
    end else if (instr_burst_acknowledge) begin
      {instrRequest, instrRequestQual} <= 2'h0;
    end
    if (instr_ready)
      words <= words + 8'h01;
    // An 8-bit length keeps every burst short of the 256-word row.
    if (instr_ready && words + 8'h01 >= burstLen)
      instr_burst_request_in <= 1'b0;
    if (goData)
      {dataRequest, dataRequestQual} <= {1'b1, !noQual};
    else if (data_ready)
      {dataRequest, dataRequestQual} <= 2'h0;
  end
endmodule

/* File: verif/vdram_ctrl_test.sv */
// Self-checking bench for the video DRAM controller.
`timescale 1ns/10ps
module vdram_ctrl_test;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addrUpper = vdram_ctrl_pkg::BLOCK_SELECT;
  logic dataWrite = 1'b0, bus_invalid = 1'b0, size_option_hi = 1'b0, size_option_lo = 1'b0;
  logic addr_bit_one = 1'b0, addr_bit_zero = 1'b0, goInstr = 1'b0, goData = 1'b0;
  logic [7:0] burstLen = 8'h04;
  logic noQual = 1'b0;
  logic otherReady = 1'b0;
  logic instrRequest, instrRequestQual, dataRequest, dataRequestQual, instr_burst_request_in;
  logic instr_burst_acknowledge, instr_ready, data_ready, data_pipeline_enable, rowStrobe;
  logic columnStrobe, addrMuxColumn, transferEnable, instrOutputEnable, shiftClockEnable;
  logic bankSelect, refreshPending;
  logic [3:0] byte_write_enables;
  int error_cnt = 0;
  int n_tests = 0;
  always #4 clock = ~clock;
  vdram_ctrl #(.REFRESH_COUNT(32)) i_dut (.clock(clock), .nrst(nrst), .addrUpper(addrUpper),
    .instrRequest(instrRequest), .instrRequestQual(instrRequestQual),
    .dataRequest(dataRequest), .dataRequestQual(dataRequestQual), .dataWrite(dataWrite),
    .instr_burst_request_in(instr_burst_request_in), .bus_invalid(bus_invalid),
    .size_option_hi(size_option_hi), .size_option_lo(size_option_lo),
    .addr_bit_one(addr_bit_one), .addr_bit_zero(addr_bit_zero),
    .instr_burst_acknowledge(instr_burst_acknowledge), .instr_ready(instr_ready),
    .data_ready(data_ready), .data_pipeline_enable(data_pipeline_enable),
    .rowStrobe(rowStrobe), .columnStrobe(columnStrobe), .addrMuxColumn(addrMuxColumn),
    .transferEnable(transferEnable), .instrOutputEnable(instrOutputEnable),
    .shiftClockEnable(shiftClockEnable), .bankSelect(bankSelect),
    .byte_write_enables(byte_write_enables), .refreshPending(refreshPending));
  cpu_model i_cpu (.clock(clock), .goInstr(goInstr), .goData(goData), .burstLen(burstLen),
    .noQual(noQual), .instr_burst_acknowledge(instr_burst_acknowledge),
    .instr_ready(instr_ready), .data_ready(data_ready | otherReady),
    .instrRequest(instrRequest), .instrRequestQual(instrRequestQual),
    .dataRequest(dataRequest), .dataRequestQual(dataRequestQual),
    .instr_burst_request_in(instr_burst_request_in));
  // A second bus slave answers every data request that is not both selected by addrUpper and qualified.
  always @(posedge clock)
    otherReady <= dataRequest && !otherReady &&
      !(addrUpper == vdram_ctrl_pkg::BLOCK_SELECT && dataRequestQual);
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic go_data(input logic [4:0] cfg);
    @(posedge clock);
    {dataWrite, size_option_hi, size_option_lo, addr_bit_one, addr_bit_zero} <= cfg;
    goData <= 1'b1;
    @(posedge clock);
    goData <= 1'b0;
    #1;
  endtask
  task automatic wait_pen;
    for (int i = 0; i < 60 && !data_pipeline_enable; i++) cyc();
    chk("pipeline enable", data_pipeline_enable, 1'b1);
  endtask
  task automatic t_instr(input logic [7:0] len);
    @(posedge clock);
    burstLen <= len;
    goInstr <= 1'b1;
    @(posedge clock);
    goInstr <= 1'b0;
    #1;
    for (int i = 0; i < 60 && !instr_burst_acknowledge; i++) cyc();
    chk("ack with strobes", {instr_burst_acknowledge, rowStrobe, columnStrobe}, 3'h7);
    cyc(3);
    chk("ready shift bank", {instr_ready, shiftClockEnable, bankSelect}, 3'h7);
  endtask
  task automatic end_burst;
    for (int i = 0; i < 300 && instr_ready; i++) cyc();
    chk("burst ended", instr_ready, 1'b0);
    cyc(4);
  endtask
  // Each write configuration is {write, size hi, size lo, addr bit one, addr bit zero}.
  task automatic t_writes;
    logic [4:0] cfg [8] = '{5'h10, 5'h18, 5'h1a, 5'h14, 5'h15, 5'h16, 5'h17, 5'h1e};
    logic [3:0] lanes [8] = '{4'hf, 4'hc, 4'h3, 4'h8, 4'h4, 4'h2, 4'h1, 4'hf};
    for (int k = 0; k < 8; k++) begin
      go_data(cfg[k]);
      wait_pen();
      chk("write ready", data_ready, 1'b1);
      chk("byte enables", byte_write_enables, lanes[k]);
      cyc(8);
    end
  endtask
  task automatic t_read;
    go_data(5'h00);
    wait_pen();
    chk("read early", {data_ready, byte_write_enables}, 5'h00);
    cyc(2);
    chk("read ready", data_ready, 1'b1);
    cyc(6);
  endtask
  task automatic t_refresh;
    logic dataRas;
    dataRas = 1'b0;
    @(posedge clock);
    bus_invalid <= 1'b1;
    go_data(5'h00);
    for (int i = 0; i < 100 && (i < 40 || !refreshPending); i++) begin
      dataRas |= rowStrobe & ~columnStrobe;
      cyc();
    end
    chk("blocked start", dataRas, 1'b0);
    @(posedge clock);
    bus_invalid <= 1'b0;
    #1;
    for (int i = 0; i < 20 && !rowStrobe; i++) cyc();
    chk("refresh first", {rowStrobe, columnStrobe}, 2'h3);
    wait_pen();
    chk("refresh cleared", refreshPending, 1'b0);
    cyc(2);
    chk("held read done", data_ready, 1'b1);
  endtask
  task automatic t_reset;
    cyc(3);
    chk("reset quiet", |{rowStrobe, columnStrobe, instr_burst_acknowledge, instr_ready,
      data_ready, data_pipeline_enable, shiftClockEnable, refreshPending}, 1'b0);
    @(posedge clock);
    nrst <= 1'b1;
    cyc(3);
  endtask
  // A request this block must not claim is left to the other slave.
  task automatic t_decode(input logic [7:0] addr, input logic qualOff);
    logic started;
    started = 1'b0;
    @(posedge clock);
    addrUpper <= addr;
    noQual <= qualOff;
    go_data(5'h00);
    repeat (12) begin
      started |= data_pipeline_enable | (rowStrobe & ~columnStrobe);
      cyc();
    end
    chk("foreign request ignored", started, 1'b0);
    chk("other slave answered", dataRequest, 1'b0);
    @(posedge clock);
    addrUpper <= vdram_ctrl_pkg::BLOCK_SELECT;
    noQual <= 1'b0;
    #1;
  endtask
  task automatic t_concurrent;
    t_instr(8'h3c);
    go_data(5'h10);
    wait_pen();
    chk("ready during data", {instr_ready, data_ready}, 2'h3);
    end_burst();
  endtask
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
  initial begin
    t_reset();
    t_instr(8'h04);
    end_burst();
    t_writes();
    t_read();
    t_decode(~vdram_ctrl_pkg::BLOCK_SELECT, 1'b0);
    t_decode(vdram_ctrl_pkg::BLOCK_SELECT, 1'b1);
    t_concurrent();
    t_instr(8'h02);
    end_burst();
    t_refresh();
    end_sim();
  end
endmodule
